// ### asc_pkg.sv
// package: frame layout, register map and field positions of the angle sensor command block
package asc_pkg;

  // ------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------
  localparam int unsigned FRAME_W     = 16;
  localparam int unsigned DATA_W      = 14;
  localparam int unsigned CNT_W       = 5;
  localparam logic [4:0]  FRAME_BITS  = 5'h10;
  localparam logic [4:0]  CNT_MAX     = 5'h1f;
  localparam int unsigned RW_BIT      = 15;
  localparam int unsigned FIELD_HI    = 14;
  localparam int unsigned FIELD_LO    = 1;
  localparam int unsigned WDATA_LO    = 2;
  localparam int unsigned EF_BIT      = 1;
  localparam int unsigned PAR_BIT     = 0;

  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [13:0] ADDR_NOP    = 14'h0000;
  localparam logic [13:0] ADDR_STATUS = 14'h335a;
  localparam logic [13:0] ADDR_CLR_EF = 14'h3380;
  localparam logic [13:0] ADDR_MRST   = 14'h33a5;
  localparam logic [13:0] ADDR_CFG    = 14'h3f20;
  localparam logic [13:0] ADDR_GAIN   = 14'h3ff8;
  localparam logic [13:0] ADDR_ANGLE  = 14'h3fff;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned ANG_WEAK_BIT   = 13;
  localparam int unsigned ANG_STRONG_BIT = 12;
  localparam int unsigned ANGLE_W        = 12;
  localparam int unsigned GAIN_W         = 6;
  localparam int unsigned ST_WEAK_BIT    = 12;
  localparam int unsigned ST_STRONG_BIT  = 11;
  localparam int unsigned ST_RANGE_BIT   = 10;
  localparam int unsigned ST_ROT_BIT     = 9;
  localparam int unsigned ST_CONV_BIT    = 8;
  localparam int unsigned ST_BUSY_BIT    = 4;
  localparam int unsigned ST_ADDR_BIT    = 2;
  localparam int unsigned ST_CLK_BIT     = 1;
  localparam int unsigned ST_PAR_BIT     = 0;
  localparam int unsigned CFG_RW_W       = 9;
  localparam int unsigned CFG_GAIN_HI    = 4;
  localparam int unsigned CFG_GAIN_LO    = 3;
  localparam logic [1:0]  CFG_RES_12BIT  = 2'h0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [5:0]  GAIN_RESET  = 6'h20;
  localparam logic [8:0]  CFG_RESET   = 9'h000;
  localparam logic [15:0] FRAME_ZERO  = 16'h0000;

  typedef enum logic [1:0] {
    ST_CMD  = 2'b01,
    ST_DATA = 2'b10
  } asc_state_t;

endpackage

// ### asc_cmd_regs.sv
// design: spi command and register layer of the rotary angle sensor
//
// Summary of operation
// - write command to master reset address resets block without data frame
// - read of clear address clears frame error flag and answers zero word
// - wrong check bit, unknown address or clock count sets frame error flag
// - frame error flag stays set until clear or master reset command executes
// - address zero is a no-effect dummy write answered with zero data field
// - gain register bits 5:0; nonzero write holds gain, stops loop
// - angle register returns 12-bit binary angle in bits 11:0
// - angle register bit 13 weak alarm, bit 12 strong alarm, read-only
// - weak alarm above max gain, strong alarm below min, else clear
// - both alarms set on major error at last angle read or busy
// - status bit 12 gain at max, bit 11 gain at min
// - status bit 10 reports bias headroom limit
// - status bit 9 reports rotation calculation overflow
// - status bit 8 reports converter overflow or unfinished offset trim
// - config bits 13:12 resolution 00, bits 11:9 read-only version
// - every answer frame carries the frame error flag
// - error flag sits in bit 1 of answer frames
// - frames hold rw in bit 15, address, even check bit 0
// - status bit 4 high while angle measurement in progress
// - status bit 2 bad address, bit 1 clock count, bit 0 check bit
module asc_cmd_regs #(
  parameter logic [2:0] VERSION_CODE = 3'h5,  // arbitrary value
  parameter logic [8:0] CFG_DEFAULT  = asc_pkg::CFG_RESET
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        spi_sck_in,
  input  wire logic        spi_cs_n_in,
  input  wire logic        spi_mosi_in,
  output logic             spi_miso_out,
  output logic             spi_miso_oe_out,
  input  wire logic [11:0] measured_angle_in,
  input  wire logic [5:0]  loop_gain_in,
  input  wire logic        gain_at_max_in,
  input  wire logic        gain_at_min_in,
  input  wire logic        bias_limit_in,
  input  wire logic        rotation_calc_overflow_in,
  input  wire logic        converter_overflow_in,
  input  wire logic        meas_busy_in,
  input  wire logic        major_error_in,
  output logic             meas_start_out,
  output logic             master_reset_out,
  output logic             gain_hold_out,
  output logic [5:0]       gain_hold_value_out,
  output logic [1:0]       config_gain_out,
  output logic             frame_error_flag_out
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic addr_known(input logic [13:0] a);
    addr_known = (a == asc_pkg::ADDR_NOP) || (a == asc_pkg::ADDR_STATUS) ||
                 (a == asc_pkg::ADDR_CLR_EF) || (a == asc_pkg::ADDR_MRST) ||
                 (a == asc_pkg::ADDR_CFG) || (a == asc_pkg::ADDR_GAIN) ||
                 (a == asc_pkg::ADDR_ANGLE);
  endfunction

  // even check bit over the upper fifteen bits
  function automatic logic [15:0] make_frame(input logic [13:0] d, input logic e);
    make_frame = {d, e, ^{d, e}};
  endfunction

  // ------------------------------------------------------------
  // link domain: shift in on falling edge, shift out on rising
  // ------------------------------------------------------------
  logic        link_fresh;
  logic [4:0]  link_count;
  logic [4:0]  next_link_count;
  logic [15:0] link_shift;
  logic [15:0] next_link_shift;
  logic        miso_bit;
  logic        next_miso_bit;
  logic [15:0] tx_word;

  // cs high arms the next frame; counts stay put so the core can read them
  always_ff @(negedge spi_sck_in or posedge spi_cs_n_in or posedge rst_in) begin
    if (rst_in || spi_cs_n_in) begin
      link_fresh <= 1'b1;
    end else begin
      link_fresh <= 1'b0;
    end
  end

  always_comb begin
    if (link_fresh) begin
      next_link_count = 5'h01;
      next_link_shift = {15'h0000, spi_mosi_in};
    end else begin
      next_link_count = (link_count == asc_pkg::CNT_MAX) ? link_count : link_count + 5'h01;
      next_link_shift = {link_shift[14:0], spi_mosi_in};
    end
  end

  always_ff @(negedge spi_sck_in or posedge rst_in) begin
    if (rst_in) begin
      link_count <= 5'h00;
      link_shift <= asc_pkg::FRAME_ZERO;
    end else begin
      link_count <= next_link_count;
      link_shift <= next_link_shift;
    end
  end

  // tx_word is only changed by the core while cs is high
  always_comb begin
    next_miso_bit = 1'b0;
    if (link_fresh) begin
      next_miso_bit = tx_word[asc_pkg::RW_BIT];
    end else if (link_count < asc_pkg::FRAME_BITS) begin
      next_miso_bit = tx_word[4'hf - link_count[3:0]];
    end
  end

  always_ff @(posedge spi_sck_in or posedge rst_in) begin
    if (rst_in) begin
      miso_bit <= 1'b0;
    end else begin
      miso_bit <= next_miso_bit;
    end
  end

  assign spi_miso_out    = miso_bit;
  assign spi_miso_oe_out = ~spi_cs_n_in;

  // ------------------------------------------------------------
  // core domain: frame end detection
  // ------------------------------------------------------------
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic frame_end;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_meta <= spi_cs_n_in;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  // link registers are frozen once cs is high, so reading them here is safe
  assign frame_end = cs_sync & ~cs_prev;

  // ------------------------------------------------------------
  // frame decode
  // ------------------------------------------------------------
  asc_pkg::asc_state_t state;
  asc_pkg::asc_state_t next_state;
  logic                rx_read;
  logic [13:0]         rx_field;
  logic                bad_par;
  logic                bad_clk;
  logic                bad_addr;
  logic                cmd_phase;
  logic                cmd_ok;
  logic                data_ok;

  assign rx_read   = link_shift[asc_pkg::RW_BIT];
  assign rx_field  = link_shift[asc_pkg::FIELD_HI:asc_pkg::FIELD_LO];
  assign bad_par   = ^link_shift;
  assign bad_clk   = link_count != asc_pkg::FRAME_BITS;
  assign bad_addr  = !addr_known(rx_field);
  assign cmd_phase = frame_end && (state == asc_pkg::ST_CMD);
  assign cmd_ok    = cmd_phase && !bad_par && !bad_clk && !bad_addr;
  assign data_ok   = frame_end && (state == asc_pkg::ST_DATA) && !bad_par && !bad_clk;

  // ------------------------------------------------------------
  // register views
  // ------------------------------------------------------------
  logic        ef;
  logic [2:0]  spi_err;
  logic [5:0]  gain_reg;
  logic        gain_hold;
  logic [8:0]  cfg_rw;
  logic        major_seen;
  logic        alarm_both;
  logic [13:0] angle_word;
  logic [13:0] status_word;
  logic [13:0] cfg_word;
  logic [13:0] gain_word;
  logic [13:0] wdata;

  assign wdata      = link_shift[asc_pkg::RW_BIT:asc_pkg::WDATA_LO];
  assign alarm_both = major_seen | meas_busy_in;

  always_comb begin
    angle_word = {2'h0, measured_angle_in};
    angle_word[asc_pkg::ANG_WEAK_BIT]   = alarm_both | gain_at_max_in;
    angle_word[asc_pkg::ANG_STRONG_BIT] = alarm_both | gain_at_min_in;
    status_word = 14'h0000;
    status_word[asc_pkg::ST_WEAK_BIT]   = gain_at_max_in;
    status_word[asc_pkg::ST_STRONG_BIT] = gain_at_min_in;
    status_word[asc_pkg::ST_RANGE_BIT]  = bias_limit_in;
    status_word[asc_pkg::ST_ROT_BIT]    = rotation_calc_overflow_in;
    status_word[asc_pkg::ST_CONV_BIT]   = converter_overflow_in;
    status_word[asc_pkg::ST_BUSY_BIT]   = meas_busy_in;
    status_word[asc_pkg::ST_ADDR_BIT]   = spi_err[asc_pkg::ST_ADDR_BIT];
    status_word[asc_pkg::ST_CLK_BIT]    = spi_err[asc_pkg::ST_CLK_BIT];
    status_word[asc_pkg::ST_PAR_BIT]    = spi_err[asc_pkg::ST_PAR_BIT];
    cfg_word  = {asc_pkg::CFG_RES_12BIT, VERSION_CODE, cfg_rw};
    gain_word = {8'h00, gain_hold ? gain_reg : loop_gain_in};
  end

  function automatic logic [13:0] reg_value(input logic [13:0] a, input logic [13:0] ang,
                                            input logic [13:0] st, input logic [13:0] cf,
                                            input logic [13:0] gn);
    reg_value = 14'h0000;
    if (a == asc_pkg::ADDR_ANGLE) reg_value = ang;
    if (a == asc_pkg::ADDR_STATUS) reg_value = st;
    if (a == asc_pkg::ADDR_CFG) reg_value = cf;
    if (a == asc_pkg::ADDR_GAIN) reg_value = gn;
  endfunction

  // ------------------------------------------------------------
  // command execution
  // ------------------------------------------------------------
  logic [13:0] pend_addr;
  logic [13:0] next_pend_addr;
  logic [15:0] next_tx_word;
  logic        next_ef;
  logic [2:0]  next_spi_err;
  logic [5:0]  next_gain_reg;
  logic        next_gain_hold;
  logic [8:0]  next_cfg_rw;
  logic        next_major_seen;
  logic        meas_start;
  logic        next_meas_start;
  logic        mrst;
  logic        next_mrst;

  always_comb begin
    next_state      = state;
    next_pend_addr  = pend_addr;
    next_tx_word    = tx_word;
    next_ef         = ef;
    next_spi_err    = spi_err;
    next_gain_reg   = gain_reg;
    next_gain_hold  = gain_hold;
    next_cfg_rw     = cfg_rw;
    next_major_seen = major_seen;
    next_meas_start = 1'b0;
    next_mrst       = 1'b0;
    if (cmd_phase && !cmd_ok) begin
      next_ef      = 1'b1;
      next_spi_err = spi_err | {bad_addr, bad_clk, bad_par};
      next_tx_word = make_frame(14'h0000, 1'b1);
    end else if (cmd_ok && rx_read && rx_field == asc_pkg::ADDR_CLR_EF) begin
      next_ef      = 1'b0;
      next_spi_err = 3'h0;
      next_tx_word = asc_pkg::FRAME_ZERO;
    end else if (cmd_ok && !rx_read && rx_field == asc_pkg::ADDR_MRST) begin
      next_state      = asc_pkg::ST_CMD;
      next_pend_addr  = asc_pkg::ADDR_NOP;
      next_tx_word    = asc_pkg::FRAME_ZERO;
      next_ef         = 1'b0;
      next_spi_err    = 3'h0;
      next_gain_reg   = asc_pkg::GAIN_RESET;
      next_gain_hold  = 1'b0;
      next_cfg_rw     = CFG_DEFAULT;
      next_major_seen = 1'b0;
      next_mrst       = 1'b1;
    end else if (cmd_ok) begin
      next_tx_word = make_frame(reg_value(rx_field, angle_word, status_word, cfg_word,
                                          gain_word), ef);
      if (rx_read && rx_field == asc_pkg::ADDR_ANGLE) begin
        next_meas_start = 1'b1;
        next_major_seen = major_error_in;
      end
      if (!rx_read && rx_field != asc_pkg::ADDR_NOP) begin
        next_state     = asc_pkg::ST_DATA;
        next_pend_addr = rx_field;
      end
    end else if (frame_end && state == asc_pkg::ST_DATA) begin
      next_state = asc_pkg::ST_CMD;
      if (!data_ok) begin
        next_ef      = 1'b1;
        next_spi_err = spi_err | {1'b0, bad_clk, bad_par};
        next_tx_word = make_frame(14'h0000, 1'b1);
      end else if (pend_addr == asc_pkg::ADDR_GAIN) begin
        next_gain_reg  = wdata[asc_pkg::GAIN_W-1:0];
        next_gain_hold = wdata[asc_pkg::GAIN_W-1:0] != 6'h00;
        next_tx_word   = make_frame({8'h00, wdata[asc_pkg::GAIN_W-1:0]}, ef);
      end else if (pend_addr == asc_pkg::ADDR_CFG) begin
        next_cfg_rw  = wdata[asc_pkg::CFG_RW_W-1:0];
        next_tx_word = make_frame({asc_pkg::CFG_RES_12BIT, VERSION_CODE,
                                   wdata[asc_pkg::CFG_RW_W-1:0]}, ef);
      end else begin
        // read-only targets ignore the data frame
        next_tx_word = make_frame(reg_value(pend_addr, angle_word, status_word, cfg_word,
                                            gain_word), ef);
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state      <= asc_pkg::ST_CMD;
      pend_addr  <= asc_pkg::ADDR_NOP;
      tx_word    <= asc_pkg::FRAME_ZERO;
      ef         <= 1'b0;
      spi_err    <= 3'h0;
      gain_reg   <= asc_pkg::GAIN_RESET;
      gain_hold  <= 1'b0;
      cfg_rw     <= CFG_DEFAULT;
      major_seen <= 1'b0;
      meas_start <= 1'b0;
      mrst       <= 1'b0;
    end else begin
      state      <= next_state;
      pend_addr  <= next_pend_addr;
      tx_word    <= next_tx_word;
      ef         <= next_ef;
      spi_err    <= next_spi_err;
      gain_reg   <= next_gain_reg;
      gain_hold  <= next_gain_hold;
      cfg_rw     <= next_cfg_rw;
      major_seen <= next_major_seen;
      meas_start <= next_meas_start;
      mrst       <= next_mrst;
    end
  end

  assign meas_start_out       = meas_start;
  assign master_reset_out     = mrst;
  assign gain_hold_out        = gain_hold;
  assign gain_hold_value_out  = gain_reg;
  assign config_gain_out      = cfg_rw[asc_pkg::CFG_GAIN_HI:asc_pkg::CFG_GAIN_LO];
  assign frame_error_flag_out = ef;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking core_cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  clear_flag_a: assert property (
    cmd_ok && rx_read && rx_field == asc_pkg::ADDR_CLR_EF |=> !ef && tx_word == 16'h0000)
    else $error("clear command did not clear flag or answer zero");

  clock_count_a: assert property (
    frame_end && bad_clk |=> ef && spi_err[asc_pkg::ST_CLK_BIT])
    else $error("wrong clock count not flagged");

  flag_sticky_a: assert property (
    ef && !(cmd_ok && rx_read && rx_field == asc_pkg::ADDR_CLR_EF)
      && !(cmd_ok && !rx_read && rx_field == asc_pkg::ADDR_MRST) |=> ef)
    else $error("frame error flag dropped without clear");

  nop_answer_a: assert property (
    cmd_ok && !rx_read && rx_field == asc_pkg::ADDR_NOP && !ef
      |=> tx_word == 16'h0000 && state == asc_pkg::ST_CMD)
    else $error("dummy write answered with nonzero word");

  gain_hold_a: assert property (
    data_ok && pend_addr == asc_pkg::ADDR_GAIN && wdata[5:0] != 6'h00
      |=> gain_hold_out && gain_hold_value_out == $past(wdata[5:0]))
    else $error("nonzero gain write did not hold gain");

  alarm_busy_a: assert property (
    cmd_ok && rx_read && rx_field == asc_pkg::ADDR_ANGLE && (major_seen || meas_busy_in)
      |=> tx_word[asc_pkg::ANG_WEAK_BIT + asc_pkg::WDATA_LO]
        && tx_word[asc_pkg::ANG_STRONG_BIT + asc_pkg::WDATA_LO])
    else $error("alarm answer without both alarms");

  answer_check_a: assert property (
    frame_end |=> ^tx_word == 1'b0 ##1 $stable(tx_word))
    else $error("answer frame has odd check bit");

  master_reset_a: assert property (
    cmd_ok && !rx_read && rx_field == asc_pkg::ADDR_MRST
      |=> master_reset_out && !gain_hold_out && !ef ##1 !master_reset_out)
    else $error("master reset command not carried out");

  config_ro_a: assert property (
    data_ok && pend_addr == asc_pkg::ADDR_CFG
      |=> tx_word[15:11] == {asc_pkg::CFG_RES_12BIT, VERSION_CODE}
        && cfg_rw == $past(wdata[asc_pkg::CFG_RW_W-1:0]))
    else $error("config write altered read-only fields");

  config_fixed_a: assert property (
    data_ok && pend_addr != asc_pkg::ADDR_CFG && pend_addr != asc_pkg::ADDR_GAIN
      |=> cfg_rw == $past(cfg_rw) && gain_reg == $past(gain_reg))
    else $error("write to read-only register changed state");

  cover_clear_c:  cover property (cmd_ok && rx_read && rx_field == asc_pkg::ADDR_CLR_EF && ef);
  cover_gain_c:   cover property (data_ok && pend_addr == asc_pkg::ADDR_GAIN);
  cover_angle_c:  cover property (cmd_ok && rx_read && rx_field == asc_pkg::ADDR_ANGLE);
  cover_reset_c:  cover property (cmd_ok && !rx_read && rx_field == asc_pkg::ADDR_MRST);

endmodule // asc_cmd_regs

// ### asc_host_model.sv
// partner model: spi host that shifts one frame at a time
module asc_host_model (
  output logic      spi_sck_out,
  output logic      spi_cs_n_out,
  output logic      spi_mosi_out,
  input  wire logic spi_miso_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // frame shifter, sck period 64 ns
  // ----------------------------------------
  initial begin
    spi_sck_out  = 1'h0;
    spi_cs_n_out = 1'h1;
    spi_mosi_out = 1'h0;
  end

  // nbits other than 16 only when a clock-count fault is wanted
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    spi_cs_n_out = 1'h0;
    #40;
    for (int i = 0; i < nbits; i++) begin
      spi_sck_out  = 1'h1;
      spi_mosi_out = tx[15-i];
      #32;
      spi_sck_out = 1'h0;
      rx = {rx[14:0], spi_miso_in};
      #32;
    end
    #20;
    spi_cs_n_out = 1'h1;
    // released line has no pull, so never leave the last bit standing
    spi_mosi_out = ~spi_mosi_out;
    #200;
  endtask
endmodule  // asc_host_model

// ### test_angle_sensor_command_registers.sv
// testbench: spi command sequences against the angle sensor command block
module test_angle_sensor_command_registers;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam logic [2:0]  VER      = 3'h5;  // arbitrary value
  localparam logic [2:0]  CASES[4] = '{3'h0, 3'h4, 3'h2, 3'h1};
  localparam logic [1:0]  ALM[4]   = '{2'h0, 2'h2, 2'h1, 2'h3};
  localparam logic [15:0] BAD[3]   = '{16'h0001, 16'h0000, 16'ha468};
  logic        core_clk_in = 1'h0;
  logic        rst_in = 1'h1;
  wire         spi_sck_in, spi_cs_n_in, spi_mosi_in;
  logic [11:0] measured_angle_in = 12'h5a3;
  logic [5:0]  loop_gain_in = 6'h20;
  logic        gain_at_max_in = 1'h0, gain_at_min_in = 1'h0, bias_limit_in = 1'h0;
  logic        rotation_calc_overflow_in = 1'h0, converter_overflow_in = 1'h0;
  logic        meas_busy_in = 1'h0, major_error_in = 1'h0;
  logic        spi_miso_out, spi_miso_oe_out, meas_start_out, master_reset_out;
  logic        gain_hold_out, frame_error_flag_out;
  logic [5:0]  gain_hold_value_out;
  logic [1:0]  config_gain_out;
  logic [15:0] rx;
  logic [13:0] cfg;
  int          n_mismatch = 0, n_checks = 0, n_cyc = 0, n_mrst = 0, n_meas = 0;

  asc_cmd_regs #(.VERSION_CODE(VER)) i_asc_cmd_regs (
    .core_clk_in, .rst_in, .spi_sck_in, .spi_cs_n_in, .spi_mosi_in, .spi_miso_out,
    .spi_miso_oe_out, .measured_angle_in, .loop_gain_in, .gain_at_max_in, .gain_at_min_in,
    .bias_limit_in, .rotation_calc_overflow_in, .converter_overflow_in, .meas_busy_in,
    .major_error_in, .meas_start_out, .master_reset_out, .gain_hold_out,
    .gain_hold_value_out, .config_gain_out, .frame_error_flag_out
  );

  asc_host_model i_asc_host_model (
    .spi_sck_out(spi_sck_in), .spi_cs_n_out(spi_cs_n_in), .spi_mosi_out(spi_mosi_in),
    .spi_miso_in(spi_miso_out)
  );

  always #5 core_clk_in = ~core_clk_in;

  // whole run needs about 6000 cycles
  always @(posedge core_clk_in) begin
    n_cyc <= n_cyc + 1;
    if (master_reset_out === 1'h1) begin
      n_mrst <= n_mrst + 1;
    end
    if (meas_start_out === 1'h1) begin
      n_meas <= n_meas + 1;
    end
    if (n_cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      give_verdict();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [15:0] pf(input logic [14:0] u);
    return {u, ^u};
  endfunction

  task automatic xf(input logic [15:0] f, input int n = 16);
    i_asc_host_model.xfer(f, n, rx);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge core_clk_in);
    rst_in <= 1'h0;
    repeat (4) @(posedge core_clk_in);
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk_in);
      {gain_at_max_in, gain_at_min_in, major_error_in} <= CASES[k];
      // the error latched at one angle read shows in the next read's answer
      xf(pf({1'h1, asc_pkg::ADDR_ANGLE}));
      xf(pf({1'h1, asc_pkg::ADDR_ANGLE}));
      xf(16'h0000);
      chk(rx, pf({ALM[k], measured_angle_in, 1'h0}));
    end
    @(posedge core_clk_in);
    {gain_at_max_in, gain_at_min_in, major_error_in} <= 3'h6;
    {bias_limit_in, rotation_calc_overflow_in, converter_overflow_in, meas_busy_in} <= 4'hf;
    xf(pf({1'h1, asc_pkg::ADDR_STATUS}));
    xf(16'h0000);
    chk(rx, pf({14'h1f10, 1'h0}));
    xf(16'h0000);
    chk(rx, 16'h0000);
    @(posedge core_clk_in);
    {gain_at_max_in, gain_at_min_in, major_error_in} <= 3'h0;
    // busy drops before any further angle read
    {bias_limit_in, rotation_calc_overflow_in, converter_overflow_in, meas_busy_in} <= 4'h0;
    xf(pf({1'h1, asc_pkg::ADDR_ANGLE}));
    xf(pf({1'h1, asc_pkg::ADDR_ANGLE}));
    xf(pf({1'h1, asc_pkg::ADDR_STATUS}));
    xf(16'h0000);
    chk(rx, 16'h0000);
    chk(16'(n_meas), 16'h000a);
    for (int e = 0; e < 3; e++) begin
      xf(BAD[e], (e == 1) ? 15 : 16);
      xf(pf({1'h1, asc_pkg::ADDR_STATUS}));
      chk(rx, 16'h0003);
      chk({15'h0000, frame_error_flag_out}, 16'h0001);
      xf(pf({1'h1, asc_pkg::ADDR_CLR_EF}));
      chk(rx, pf({14'(1 << e), 1'h1}));
      xf(16'h0000);
      chk(rx, 16'h0000);
      chk({15'h0000, frame_error_flag_out}, 16'h0000);
    end
    xf(pf({1'h0, asc_pkg::ADDR_GAIN}));
    xf(pf({14'h0015, 1'h0}));
    chk(rx, pf({14'h0020, 1'h0}));
    xf(16'h0000);
    chk(rx, pf({14'h0015, 1'h0}));
    chk({9'h000, gain_hold_out, gain_hold_value_out}, 16'h0055);
    xf(pf({1'h0, asc_pkg::ADDR_GAIN}));
    xf(16'h0000);
    chk({15'h0000, gain_hold_out}, 16'h0000);
    xf(pf({1'h1, asc_pkg::ADDR_CFG}));
    xf(pf({1'h0, asc_pkg::ADDR_CFG}));
    chk(rx, pf({2'h0, VER, 9'h000, 1'h0}));
    // read-only bits set on purpose, factory bits kept
    cfg = rx[15:2] | 14'h3e00;
    cfg[4:3] = 2'h2;
    xf(pf({cfg, 1'h0}));
    xf(16'h0000);
    chk(rx, pf({2'h0, VER, 9'h010, 1'h0}));
    chk({14'h0000, config_gain_out}, 16'h0002);
    xf(pf({1'h0, asc_pkg::ADDR_ANGLE}));
    xf(pf({14'h3fff, 1'h0}));
    xf(pf({1'h1, asc_pkg::ADDR_ANGLE}));
    xf(16'h0000);
    chk(rx, pf({2'h0, measured_angle_in, 1'h0}));
    xf(pf({1'h0, asc_pkg::ADDR_MRST}));
    chk({14'h0000, config_gain_out}, 16'h0000);
    chk(16'(n_mrst), 16'h0001);
    xf(pf({1'h1, asc_pkg::ADDR_CFG}));
    chk(rx, 16'h0000);
    xf(16'h0000);
    chk(rx, pf({2'h0, VER, 9'h000, 1'h0}));
    chk({15'h0000, spi_miso_oe_out}, 16'h0000);
    give_verdict();
  end
endmodule  // test_angle_sensor_command_registers
